/* File: inc/pbs_pkg.sv */
// What this block does
// - The active-high second select is sampled on the clock only when a new address is loaded and joins the other selects.
// - The active-low third select is sampled only at address load, and a variant without it reads as always asserted.
// - A low output enable lets the data lines drive, a high one releases them so they can act as inputs.
// - On the first clock of a read that follows the deselected state the output enable is ignored and the lines stay released.
// - A low burst step at a clock edge moves the burst address to the next location of the chosen order.
// - Either address strobe low at a clock edge captures the address and loads its two low bits into the burst counter.
// - When both strobes are low together only the processor strobe is acted on.
// - The processor strobe is ignored whenever the primary select is sampled high.
// - A high sleep request puts the port in a quiet sleep state that keeps stored contents.
// - The sleep request is held low in normal use, and an unconnected request reads as inactive.
// - Incoming data is registered on the clock, and read data is for the address given at the previous rise.
// - A low order strap gives linear bursts and a high or floating strap gives interleaved bursts.
// - Interleaved order forms each burst address as the start bits exclusive-or the count 00, 01, 10, 11.
// - The burst counter is two bits wide and wraps, never carrying into the upper address bits.
`default_nettype none
package pbs_pkg;
  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic [1:0] BURST_ONE = 2'h1;
  // ----------------------------------------
  // Sampled control inputs
  // ----------------------------------------
  typedef struct packed {
    logic select_primary_low;
    logic select_high_input;
    logic select_third_low;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_step_n;
    logic write_n;
  } pbs_ctl_t;
endpackage : pbs_pkg
`default_nettype wire

/* File: logic/pbs_port.sv */
`default_nettype none
module pbs_port #(
  parameter int ADDR_W = pbs_pkg::ADDR_W,
  parameter int DATA_W = pbs_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Synchronous control and address
  input wire pbs_pkg::pbs_ctl_t ctl,
  input wire logic [ADDR_W-1:0] addr,
  // Asynchronous pins
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_strap,
  // Data lines, split
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Array side
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_read,
  output logic mem_write,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic [DATA_W-1:0] mem_rdata,
  // Status
  output logic asleep
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic oe_n_m_r, oe_n_s_r, slp_m_r, slp_s_r, mode_m_r, mode_s_r;
  logic interleave_r;
  always_ff @(posedge clk)
  begin
    oe_n_m_r <= output_enable_n;
    oe_n_s_r <= oe_n_m_r;
    slp_m_r <= sleep_request;
    slp_s_r <= slp_m_r;
    mode_m_r <= burst_order_strap;
    mode_s_r <= mode_m_r;
  end
  // Strap caught after reset; static by system promise
  always_ff @(posedge clk)
  begin
    if (rst)
      interleave_r <= 1'b1;
    else
      interleave_r <= mode_s_r;
  end
  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  wire p_take = !ctl.processor_addr_strobe_n && !ctl.select_primary_low;
  wire c_take = !ctl.controller_addr_strobe_n && ctl.processor_addr_strobe_n;
  wire load = (p_take || c_take) && !slp_s_r;
  // Third select absent variants tie it low
  wire sel_all = !ctl.select_primary_low && ctl.select_high_input
    && !ctl.select_third_low;
  wire step = !ctl.burst_step_n && !load && !slp_s_r;
  // ----------------------------------------
  // Address and burst counter
  // ----------------------------------------
  typedef enum {ST_IDLE, ST_READ, ST_WRITE, ST_SLEEP} pbs_state_t;
  pbs_state_t state_r, state_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [1:0] start_r, count_r, count_nxt;
  logic first_r, first_nxt;
  wire [1:0] burst_bits = interleave_r ? (start_r ^ count_r)
    : 2'(start_r + count_r);
  assign count_nxt = load ? pbs_pkg::BURST_RST
    : (step ? 2'(count_r + pbs_pkg::BURST_ONE) : count_r);
  always_comb
  begin
    state_nxt = state_r;
    first_nxt = 1'b0;
    case (state_r)
      ST_IDLE, ST_READ, ST_WRITE:
      begin
        if (slp_s_r)
          state_nxt = ST_SLEEP;
        else if (load && sel_all)
        begin
          state_nxt = ctl.write_n ? ST_READ : ST_WRITE;
          first_nxt = ctl.write_n && (state_r == ST_IDLE);
        end
        else if (load && !sel_all)
          state_nxt = ST_IDLE;
      end
      ST_SLEEP:
        if (!slp_s_r)
          state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      addr_r <= '0;
      start_r <= pbs_pkg::BURST_RST;
      count_r <= pbs_pkg::BURST_RST;
      first_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      first_r <= first_nxt;
      count_r <= count_nxt;
      if (load)
      begin
        addr_r <= addr;
        start_r <= addr[1:0];
      end
    end
  end
  // ----------------------------------------
  // Array access and data path
  // ----------------------------------------
  assign mem_addr = {addr_r[ADDR_W-1:2], burst_bits};
  assign mem_read = (state_r == ST_READ);
  logic [DATA_W-1:0] wdata_r, rdata_r;
  logic wr_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wdata_r <= '0;
      rdata_r <= '0;
      wr_r <= 1'b0;
    end
    else
    begin
      wdata_r <= data_in;
      wr_r <= (state_r == ST_WRITE) && !first_r;
      rdata_r <= mem_rdata;
    end
  end
  assign mem_write = wr_r;
  assign mem_wdata = wdata_r;
  assign data_out = rdata_r;
  // Enable path is sampled; true async would need a pad-level gate
  assign data_oe = !oe_n_s_r && (state_r == ST_READ) && !first_r;
  assign asleep = (state_r == ST_SLEEP);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_first_masked;
    @(posedge clk) disable iff (rst) first_r |-> !data_oe;
  endproperty
  a_first_masked: assert property (p_first_masked)
    else $error("oe not masked");
  property p_oe_high_off;
    @(posedge clk) disable iff (rst) oe_n_s_r |-> !data_oe;
  endproperty
  a_oe_high_off: assert property (p_oe_high_off)
    else $error("drive while oe high");
  property p_load_addr;
    @(posedge clk) disable iff (rst) load |=> addr_r == $past(addr);
  endproperty
  a_load_addr: assert property (p_load_addr)
    else $error("address not captured");
  property p_pref;
    @(posedge clk) disable iff (rst)
      (!ctl.processor_addr_strobe_n && ctl.select_primary_low
       && !ctl.controller_addr_strobe_n) |-> !load;
  endproperty
  a_pref: assert property (p_pref)
    else $error("strobe taken while ignored");
  property p_step;
    @(posedge clk) disable iff (rst)
      step |=> count_r == 2'($past(count_r) + 2'h1);
  endproperty
  a_step: assert property (p_step)
    else $error("burst did not step");
  property p_inter;
    @(posedge clk) disable iff (rst)
      interleave_r |-> mem_addr[1:0] == (start_r ^ count_r);
  endproperty
  a_inter: assert property (p_inter)
    else $error("interleave order wrong");
  property p_linear;
    @(posedge clk) disable iff (rst)
      !interleave_r |-> mem_addr[1:0] == 2'(start_r + count_r);
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear order wrong");
  sequence s_sleep_held;
    slp_s_r [*2];
  endsequence
  property p_sleep;
    @(posedge clk) disable iff (rst) s_sleep_held |=> asleep && !data_oe;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep not entered");
  property p_rdata;
    @(posedge clk) disable iff (rst) !rst |=> data_out == $past(mem_rdata);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data not registered");
  // ----------------------------------------
  // Checks: selection and load
  // ----------------------------------------
  sequence s_read_load;
    load && sel_all && ctl.write_n;
  endsequence
  sequence s_fresh_read;
    load && sel_all && ctl.write_n && (state_r == ST_IDLE);
  endsequence
  property p_reset_idle;
    @(posedge clk)
      rst |=> !data_oe && !mem_read && !asleep;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("not idle after reset");
  property p_desel;
    @(posedge clk) disable iff (rst)
      (load && !sel_all) |=> !mem_read && !data_oe;
  endproperty
  a_desel: assert property (p_desel)
    else $error("deselect not honoured");
  property p_read_sel;
    @(posedge clk) disable iff (rst)
      s_read_load |=> mem_read && mem_addr == $past(addr);
  endproperty
  a_read_sel: assert property (p_read_sel)
    else $error("read not started at address");
  property p_first_read;
    @(posedge clk) disable iff (rst)
      s_fresh_read |=> first_r;
  endproperty
  a_first_read: assert property (p_first_read)
    else $error("first read cycle not marked");
  property p_first_once;
    @(posedge clk) disable iff (rst)
      first_r |=> !first_r;
  endproperty
  a_first_once: assert property (p_first_once)
    else $error("mask longer than one cycle");
  // ----------------------------------------
  // Checks: burst counter
  // ----------------------------------------
  property p_load_count;
    @(posedge clk) disable iff (rst)
      load |=> count_r == pbs_pkg::BURST_RST && start_r == $past(addr[1:0]);
  endproperty
  a_load_count: assert property (p_load_count)
    else $error("burst start not loaded");
  property p_no_step_load;
    @(posedge clk) disable iff (rst)
      (load && !ctl.burst_step_n) |=> count_r == pbs_pkg::BURST_RST;
  endproperty
  a_no_step_load: assert property (p_no_step_load)
    else $error("stepped in load cycle");
  property p_hold;
    @(posedge clk) disable iff (rst)
      (!load && ctl.burst_step_n) |=> count_r == $past(count_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("burst moved without step");
  // ----------------------------------------
  // Checks: data lines and sleep
  // ----------------------------------------
  property p_oe_low_on;
    @(posedge clk) disable iff (rst)
      (state_r == ST_READ && !first_r && !oe_n_s_r) |-> data_oe;
  endproperty
  a_oe_low_on: assert property (p_oe_low_on)
    else $error("no drive while oe low");
  property p_write_tri;
    @(posedge clk) disable iff (rst)
      (state_r == ST_WRITE) |-> !data_oe;
  endproperty
  a_write_tri: assert property (p_write_tri)
    else $error("drive during write");
  property p_mem_write;
    @(posedge clk) disable iff (rst)
      (state_r == ST_WRITE && !first_r) |=> mem_write;
  endproperty
  a_mem_write: assert property (p_mem_write)
    else $error("write not committed");
  property p_wdata;
    @(posedge clk) disable iff (rst)
      !rst |=> mem_wdata == $past(data_in);
  endproperty
  a_wdata: assert property (p_wdata)
    else $error("write data not registered");
  property p_sleep_refuse;
    @(posedge clk) disable iff (rst)
      slp_s_r |-> !load;
  endproperty
  a_sleep_refuse: assert property (p_sleep_refuse)
    else $error("strobe taken asleep");
  property p_sleep_quiet;
    @(posedge clk) disable iff (rst)
      asleep |-> !mem_read;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("array read asleep");
  sequence s_wake_start;
    asleep && !slp_s_r;
  endsequence
  property p_wake;
    @(posedge clk) disable iff (rst)
      s_wake_start |=> !asleep;
  endproperty
  a_wake: assert property (p_wake)
    else $error("sleep not left");
endmodule : pbs_port
`default_nettype wire

/* File: dv/pbs_array_model.sv */
`default_nettype none
module pbs_array_model (
  // Array side
  input wire logic [17:0] mem_addr,
  input wire logic mem_read,
  output logic [35:0] mem_rdata
);
  // Outside reads the data turns over, so stale data never matches
  assign mem_rdata = mem_read ? {~mem_addr, mem_addr} : {mem_addr, ~mem_addr};
endmodule : pbs_array_model
`default_nettype wire

/* File: dv/pbs_port_tb_top.sv */
`default_nettype none
module pbs_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Stimulus and taps
  // ----
  logic clk = 1'b0;
  logic rst = 1'b1;
  pbs_pkg::pbs_ctl_t ctl = 7'h2f;
  logic [17:0] addr = 18'h0;
  logic oe_n = 1'b1;
  logic slp = 1'b0;
  logic strap = 1'b1;
  logic [35:0] din = 36'h0;
  logic [35:0] dout, wd, rd;
  logic [17:0] ma;
  logic doe, mr, mw, slept;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  initial forever #20 clk = ~clk;
  pbs_port dut_u (.clk(clk), .rst(rst), .ctl(ctl), .addr(addr),
    .output_enable_n(oe_n), .sleep_request(slp), .burst_order_strap(strap),
    .data_in(din), .data_out(dout), .data_oe(doe), .mem_addr(ma),
    .mem_read(mr), .mem_write(mw), .mem_wdata(wd), .mem_rdata(rd),
    .asleep(slept));
  pbs_array_model arr_u (.mem_addr(ma), .mem_read(mr), .mem_rdata(rd));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(string what, logic [35:0] exp, logic [35:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("BAD %s exp %h got %h", what, exp, got);
      errors++;
    end
  endtask : chk
  task automatic load(logic [6:0] c, logic [17:0] a);
    ctl = c;
    addr = a;
    @(negedge clk);
    ctl = 7'h2f;
  endtask : load
  task automatic burst(logic s, logic [17:0] a);
    logic [1:0] b;
    strap = s;
    repeat (3) @(negedge clk);
    load(7'h6b, 18'h0);
    load(7'h2b, a);
    chk("addr", {18'h0, a}, {18'h0, ma});
    chk("oe1", 1'b0, doe);
    ctl = 7'h2d;
    for (int k = 1; k < 5; k++)
    begin
      @(negedge clk);
      if (k == 1) chk("rdat", {~a, a}, dout);
      if (k == 1) chk("oe2", 1'b1, doe);
      b = s ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
      chk("step", {18'h0, a[17:2], b}, {18'h0, ma});
    end
    ctl = 7'h2f;
    $display("burst test done");
  endtask : burst
  task automatic t_strobes();
    load(7'h3b, 18'h0);
    chk("desel3", 1'b0, mr);
    load(7'h67, 18'h155);
    chk("pign", 1'b0, mr);
    load(7'h0b, 18'h155);
    chk("desel2", 1'b0, mr);
    load(7'h23, 18'h2a6);
    chk("both", {18'h0, 18'h2a6}, {18'h0, ma});
    chk("oe1b", 1'b0, doe);
    din = 36'h9_8765_4321;
    @(negedge clk);
    chk("wdat", 36'h9_8765_4321, wd);
    oe_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("oeoff", 1'b0, doe);
    oe_n = 1'b0;
    load(7'h2a, 18'h3c);
    chk("mw0", 1'b0, mw);
    @(negedge clk);
    chk("mw1", 1'b1, mw);
    chk("oewr", 1'b0, doe);
    $display("strobe test done");
  endtask : t_strobes
  task automatic t_sleep();
    load(7'h3b, 18'h0);
    slp = 1'b1;
    repeat (4) @(negedge clk);
    chk("asleep", 1'b1, slept);
    load(7'h2b, 18'h11);
    chk("slpign", 1'b0, mr);
    slp = 1'b0;
    repeat (4) @(negedge clk);
    chk("awake", 1'b0, slept);
    $display("sleep test done");
  endtask : t_sleep
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    oe_n = 1'b0;
    burst(1'b1, {16'h1234, 2'h1});
    burst(1'b0, {16'habcd, 2'h3});
    t_strobes();
    t_sleep();
    tally_and_finish();
  end
endmodule : pbs_port_tb_top
`default_nettype wire
